// ===== hw/ogc_params.svh
// Offsets, reset values, field positions and timing counts for the correction block
`ifndef OGC_PARAMS_SVH
`define OGC_PARAMS_SVH

// Data widths
`define OGC_RAW_W 24
`define OGC_OUT_W 16
`define OGC_SPAN_FRAC 23

// Correction register reset values and span saturation value
`define OGC_ZERO_RST 24'h000000
`define OGC_SPAN_RST 24'h800000
`define OGC_SPAN_MAX 24'hffffff

// Raw code of a nominal full-scale input, as a power of two
`define OGC_FS_LOG2 22

// Right shift from the corrected raw scale to the 16-bit output scale
`define OGC_OUT_SHIFT 7

// Output limits, bipolar and unipolar
`define OGC_BIP_MAX 16'h7fff
`define OGC_BIP_MIN 16'h8000
`define OGC_UNI_MAX 16'hffff
`define OGC_UNI_MIN 16'h0000

// Calibration kind codes on the command port
`define OGC_KIND_SELF_ZERO 2'h0
`define OGC_KIND_SELF_SPAN 2'h1
`define OGC_KIND_SYS_ZERO 2'h2
`define OGC_KIND_SYS_SPAN 2'h3

// Input selector codes that route the internal temperature sensor
`define OGC_TEMP_POS_SEL 4'h7
`define OGC_TEMP_NEG_SEL 4'h0

// Quotient bits produced by the reciprocal divider, one per cycle
`define OGC_DIV_STEPS 24

`endif

// ===== hw/ogc_pkg.sv
// Types shared by the offset and gain correction block
package ogc_pkg;

	// Calibration sequencer states
	typedef enum logic [1:0] {
		CAL_IDLE,
		CAL_CONV,
		CAL_DIV
	} ogc_cal_e;

	// Whole state of the correction datapath
	typedef struct packed {
		ogc_cal_e cal;
		logic [1:0] kind;
		logic [23:0] zero;
		logic [23:0] span;
		logic conv_v;
		logic [49:0] prod;
		logic uni;
		logic [1:0] amp;
		logic [15:0] data;
		logic data_rdy;
		logic cal_done;
		logic short_in;
		logic ref_in;
		logic div_go;
		logic [23:0] div_den;
		logic temp_sel;
	} ogc_state_s;

	// Whole state of the reciprocal divider
	typedef struct packed {
		logic busy;
		logic done;
		logic [4:0] step;
		logic [24:0] rem;
		logic [23:0] quo;
	} ogc_div_s;

endpackage : ogc_pkg

// ===== hw/ogc_recip.sv
// Reciprocal divider: span = 2^45 / divisor, saturated to 24 bits
`timescale 1ns/1ps
`default_nettype none
`include "ogc_params.svh"

module ogc_recip
	import ogc_pkg::*;
#(
	parameter int STEPS = `OGC_DIV_STEPS
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Request
	input wire logic start,
	input wire logic [23:0] divisor,
	// Answer
	output logic busy,
	output logic done,
	output logic [23:0] quotient
);

	localparam logic [24:0] SEED = 25'h1 << `OGC_FS_LOG2 - 1;
	localparam logic [4:0] LAST = 5'(STEPS - 1);

	ogc_div_s s_r;
	ogc_div_s s_nxt;
	logic [24:0] trial;

	// Restoring division, one quotient bit per clock
	always_comb begin
		s_nxt = s_r;
		s_nxt.done = 1'b0;
		trial = {s_r.rem[23:0], 1'b0};
		if (start && !s_r.busy) begin
			// Too small a divisor would give a quotient past 24 bits
			if ({1'b0, divisor} <= SEED) begin
				s_nxt.quo = `OGC_SPAN_MAX;
				s_nxt.done = 1'b1;
			end else begin
				s_nxt.busy = 1'b1;
				s_nxt.rem = SEED;
				s_nxt.step = 5'h0;
				s_nxt.quo = 24'h000000;
			end
		end else if (s_r.busy) begin
			if (trial >= {1'b0, divisor}) begin
				s_nxt.rem = trial - {1'b0, divisor};
				s_nxt.quo = {s_r.quo[22:0], 1'b1};
			end else begin
				s_nxt.rem = trial;
				s_nxt.quo = {s_r.quo[22:0], 1'b0};
			end
			s_nxt.step = s_r.step + 5'h1;
			if (s_r.step == LAST) begin
				s_nxt.busy = 1'b0;
				s_nxt.done = 1'b1;
			end
		end
	end

	// State register
	always_ff @(posedge clk) begin
		if (rst) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign busy = s_r.busy;
	assign done = s_r.done;
	assign quotient = s_r.quo;

endmodule : ogc_recip

`default_nettype wire

// ===== hw/ogc_top.sv
// Offset and gain correction datapath with self and system calibration
`timescale 1ns/1ps
`default_nettype none
`include "ogc_params.svh"

module ogc_top
	import ogc_pkg::*;
(
	// Clock and reset
	input wire logic CORE_CLK,
	input wire logic RST,
	// Raw results from the decimation filter
	input wire logic RAW_VALID,
	input wire logic [23:0] RAW_DATA,
	// Mode settings
	input wire logic UNIPOLAR,
	input wire logic [1:0] AMP_GAIN,
	input wire logic [3:0] POSITIVE_INPUT_SELECT,
	input wire logic [3:0] NEGATIVE_INPUT_SELECT,
	// Correction register writes
	input wire logic ZERO_WR,
	input wire logic [23:0] ZERO_WDATA,
	input wire logic SPAN_WR,
	input wire logic [23:0] SPAN_WDATA,
	// Calibration command
	input wire logic CAL_START,
	input wire logic [1:0] CAL_KIND,
	// Correction register readback
	output logic [23:0] ZERO_CORRECTION,
	output logic [23:0] SPAN_CORRECTION,
	// Output data word
	output logic [15:0] DATA_OUT,
	output logic DATA_READY,
	// Calibration status and front-end routing
	output logic CAL_BUSY,
	output logic CAL_DONE,
	output logic SHORT_INPUTS,
	output logic REF_TO_INPUT,
	output logic TEMP_SENSE_SEL
);

	ogc_state_s s_r;
	ogc_state_s s_nxt;

	// Reciprocal divider handshake
	logic div_busy;
	logic div_done;
	logic [23:0] div_quo;

	// Datapath intermediates
	logic signed [24:0] diff;
	logic signed [49:0] prod_now;
	logic signed [33:0] scaled;
	logic signed [33:0] shifted;
	logic signed [33:0] out_scale;
	logic [15:0] out_word;

	// Amplifier gain code to left-shift count
	function automatic logic [1:0] amp_shift(input logic [1:0] code);
		amp_shift = code;
	endfunction : amp_shift

	// Clamp to the 16-bit range of the selected polarity
	function automatic logic [15:0] clamp16(
		input logic signed [33:0] v,
		input logic uni
	);
		logic signed [33:0] hi;
		logic signed [33:0] lo;
		hi = uni ? 34'sh0ffff : 34'sh07fff;
		lo = uni ? 34'sh00000 : -34'sh08000;
		if (v > hi) begin
			clamp16 = uni ? `OGC_UNI_MAX : `OGC_BIP_MAX;
		end else if (v < lo) begin
			clamp16 = uni ? `OGC_UNI_MIN : `OGC_BIP_MIN;
		end else begin
			clamp16 = v[15:0];
		end
	endfunction : clamp16

	// Raw minus zero correction, both read as signed
	always_comb begin
		diff = $signed({RAW_DATA[23], RAW_DATA})
			- $signed({s_r.zero[23], s_r.zero});
		prod_now = diff * $signed({1'b0, s_r.span});
	end

	// Second stage: drop fraction, apply amplifier and unipolar gain
	always_comb begin
		// Stored product field is unsigned; re-sign it so negatives shift arithmetically
		scaled = 34'($signed(s_r.prod) >>> `OGC_SPAN_FRAC);
		shifted = scaled <<< amp_shift(s_r.amp);
		if (s_r.uni) begin
			// Negative values go to zero before doubling
			out_scale = (shifted < 34'sh0) ? 34'sh0 : (shifted <<< 1);
		end else begin
			out_scale = shifted;
		end
		out_word = clamp16(out_scale >>> `OGC_OUT_SHIFT, s_r.uni);
	end

	// Sequencer and register next state
	always_comb begin
		s_nxt = s_r;
		s_nxt.conv_v = 1'b0;
		s_nxt.data_rdy = 1'b0;
		s_nxt.cal_done = 1'b0;
		s_nxt.div_go = 1'b0;
		s_nxt.temp_sel = (POSITIVE_INPUT_SELECT == `OGC_TEMP_POS_SEL)
			&& (NEGATIVE_INPUT_SELECT == `OGC_TEMP_NEG_SEL);

		// Software writes; a calibration store below overrides them
		if (ZERO_WR) begin
			s_nxt.zero = ZERO_WDATA;
		end
		if (SPAN_WR) begin
			s_nxt.span = SPAN_WDATA;
		end

		unique case (s_r.cal)
			CAL_IDLE: begin
				if (CAL_START) begin
					s_nxt.cal = CAL_CONV;
					s_nxt.kind = CAL_KIND;
					s_nxt.short_in = (CAL_KIND == `OGC_KIND_SELF_ZERO);
					s_nxt.ref_in = (CAL_KIND == `OGC_KIND_SELF_SPAN);
				end else if (RAW_VALID) begin
					// Mode is sampled with the result, so later changes wait
					s_nxt.conv_v = 1'b1;
					s_nxt.prod = prod_now;
					s_nxt.uni = UNIPOLAR;
					s_nxt.amp = AMP_GAIN;
				end
			end
			CAL_CONV: begin
				// Gain and polarity are not used here, only the raw code and the stored zero
				if (RAW_VALID) begin
					s_nxt.short_in = 1'b0;
					s_nxt.ref_in = 1'b0;
					if (s_r.kind == `OGC_KIND_SELF_ZERO
						|| s_r.kind == `OGC_KIND_SYS_ZERO) begin
						s_nxt.zero = RAW_DATA;
						s_nxt.cal = CAL_IDLE;
						s_nxt.cal_done = 1'b1;
					end else begin
						// Uses the stored zero, hence offset first
						// Negative difference maps to zero, which the divider saturates
						s_nxt.div_den = diff[24] ? 24'h000000 : diff[23:0];
						s_nxt.div_go = 1'b1;
						s_nxt.cal = CAL_DIV;
					end
				end
			end
			CAL_DIV: begin
				if (div_done) begin
					s_nxt.span = div_quo;
					s_nxt.cal = CAL_IDLE;
					s_nxt.cal_done = 1'b1;
				end
			end
			default: begin
				s_nxt.cal = CAL_IDLE;
			end
		endcase

		// Output word changes only when a conversion finishes
		if (s_r.conv_v) begin
			s_nxt.data = out_word;
			s_nxt.data_rdy = 1'b1;
		end
	end

	// State register
	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			s_r <= '0;
			s_r.cal <= CAL_IDLE;
			s_r.zero <= `OGC_ZERO_RST;
			s_r.span <= `OGC_SPAN_RST;
		end else begin
			s_r <= s_nxt;
		end
	end

	// Reciprocal for span calibration
	ogc_recip #(
		.STEPS(`OGC_DIV_STEPS)
	) u_recip (
		.clk(CORE_CLK),
		.rst(RST),
		.start(s_r.div_go),
		.divisor(s_r.div_den),
		.busy(div_busy),
		.done(div_done),
		.quotient(div_quo)
	);

	// Outputs straight from the state register
	assign ZERO_CORRECTION = s_r.zero;
	assign SPAN_CORRECTION = s_r.span;
	assign DATA_OUT = s_r.data;
	assign DATA_READY = s_r.data_rdy;
	assign CAL_BUSY = (s_r.cal != CAL_IDLE);
	assign CAL_DONE = s_r.cal_done;
	assign SHORT_INPUTS = s_r.short_in;
	assign REF_TO_INPUT = s_r.ref_in;
	assign TEMP_SENSE_SEL = s_r.temp_sel;

endmodule : ogc_top

`default_nettype wire

// ===== tb/ogc_top_asserts.sv
// Port-level checks for the correction block
`timescale 1ns/1ps
`default_nettype none
module ogc_top_asserts (
	// Clock and reset
	input wire logic CORE_CLK,
	input wire logic RST,
	// Inputs watched
	input wire logic RAW_VALID,
	input wire logic [23:0] RAW_DATA,
	input wire logic [3:0] POSITIVE_INPUT_SELECT,
	input wire logic [3:0] NEGATIVE_INPUT_SELECT,
	input wire logic SPAN_WR,
	input wire logic [23:0] SPAN_WDATA,
	input wire logic CAL_START,
	input wire logic [1:0] CAL_KIND,
	// Outputs watched
	input wire logic [23:0] ZERO_CORRECTION,
	input wire logic [23:0] SPAN_CORRECTION,
	input wire logic [15:0] DATA_OUT,
	input wire logic DATA_READY,
	input wire logic CAL_BUSY,
	input wire logic CAL_DONE,
	input wire logic SHORT_INPUTS,
	input wire logic REF_TO_INPUT,
	input wire logic TEMP_SENSE_SEL
);
	default clocking cb @(posedge CORE_CLK);
	endclocking
	default disable iff (RST);
	// Calibration launch and raw capture steps
	sequence cal_go(logic [1:0] k);
		CAL_START && !CAL_BUSY && CAL_KIND == k;
	endsequence
	sequence zero_take;
		SHORT_INPUTS && RAW_VALID;
	endsequence
	reset_vals_a: assert property ($fell(RST) |-> ZERO_CORRECTION == 24'h000000
		&& SPAN_CORRECTION == 24'h800000 && DATA_OUT == 16'h0000)
		else $error("reset values wrong");
	data_hold_a: assert property (!DATA_READY |-> $stable(DATA_OUT))
		else $error("output word moved without ready");
	ready_lat_a: assert property (RAW_VALID && !CAL_BUSY && !CAL_START |-> ##2 DATA_READY)
		else $error("ready not two cycles after raw");
	zero_short_a: assert property (cal_go(2'h0) |=> SHORT_INPUTS && CAL_BUSY)
		else $error("self offset did not short inputs");
	zero_store_a: assert property (zero_take |=> ZERO_CORRECTION == $past(RAW_DATA)
		&& CAL_DONE && !CAL_BUSY)
		else $error("offset result not stored");
	span_done_a: assert property (REF_TO_INPUT && RAW_VALID |-> ##[1:40] CAL_DONE)
		else $error("gain calibration did not finish");
	span_wr_a: assert property (SPAN_WR && !CAL_BUSY |=> SPAN_CORRECTION == $past(SPAN_WDATA))
		else $error("span write lost");
	temp_sel_a: assert property (POSITIVE_INPUT_SELECT == 4'h7
		&& NEGATIVE_INPUT_SELECT == 4'h0 |=> TEMP_SENSE_SEL)
		else $error("temperature route missed");
endmodule : ogc_top_asserts
bind ogc_top ogc_top_asserts u_chk (.CORE_CLK(CORE_CLK), .RST(RST), .RAW_VALID(RAW_VALID),
	.RAW_DATA(RAW_DATA), .POSITIVE_INPUT_SELECT(POSITIVE_INPUT_SELECT),
	.NEGATIVE_INPUT_SELECT(NEGATIVE_INPUT_SELECT), .SPAN_WR(SPAN_WR), .SPAN_WDATA(SPAN_WDATA),
	.CAL_START(CAL_START), .CAL_KIND(CAL_KIND), .ZERO_CORRECTION(ZERO_CORRECTION),
	.SPAN_CORRECTION(SPAN_CORRECTION), .DATA_OUT(DATA_OUT), .DATA_READY(DATA_READY),
	.CAL_BUSY(CAL_BUSY), .CAL_DONE(CAL_DONE), .SHORT_INPUTS(SHORT_INPUTS),
	.REF_TO_INPUT(REF_TO_INPUT), .TEMP_SENSE_SEL(TEMP_SENSE_SEL));
`default_nettype wire

// ===== tb/ogc_filter_model.sv
// Decimation filter stand-in, one raw result per request
`timescale 1ns/1ps
`default_nettype none
module ogc_filter_model (
	// Clock
	input wire logic clk,
	// Request from the bench
	input wire logic go,
	input wire logic [23:0] value,
	// Raw result
	output logic raw_valid = 1'b0,
	output logic [23:0] raw_data = 24'h000000
);
	logic [23:0] last_r = 24'h000000;
	// Stale data is inverted between results so it never passes for fresh
	always_ff @(posedge clk) begin
		raw_valid <= go;
		raw_data <= go ? value : ~last_r;
		if (go) begin
			last_r <= value;
		end
	end
endmodule : ogc_filter_model
`default_nettype wire

// ===== tb/tb_top.sv
// Self-checking bench for the correction block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic clk = 1'b0, rst = 1'b1, go = 1'b0, uni = 1'b0, zwr = 1'b0, swr = 1'b0, cst = 1'b0;
	logic [1:0] gain = 2'h0, kind = 2'h0;
	logic [3:0] psel = 4'h1, nsel = 4'h0;
	logic [23:0] val = 24'h0, zwd = 24'h0, swd = 24'h0, zexp = 24'h0, sexp = 24'h800000;
	logic rv, rdy, done, tsel;
	logic [23:0] rd, zc, sc;
	logic [15:0] dout, held;
	logic [23:0] raws [5] = '{24'h100000, 24'hf00000, 24'h7fffff, 24'h800000, 24'h0ff000};
	logic [1:0] ckind [5] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h3};
	logic [23:0] craw [5] = '{24'h000123, 24'h500123, 24'hfff000, 24'h3ff000, 24'h000100};
	int errors = 0, checked = 0;
	// Filter stand-in and block under test
	ogc_filter_model filt (.clk(clk), .go(go), .value(val), .raw_valid(rv), .raw_data(rd));
	ogc_top uut (.CORE_CLK(clk), .RST(rst), .RAW_VALID(rv), .RAW_DATA(rd), .UNIPOLAR(uni),
		.AMP_GAIN(gain), .POSITIVE_INPUT_SELECT(psel), .NEGATIVE_INPUT_SELECT(nsel),
		.ZERO_WR(zwr), .ZERO_WDATA(zwd), .SPAN_WR(swr), .SPAN_WDATA(swd), .CAL_START(cst),
		.CAL_KIND(kind), .ZERO_CORRECTION(zc), .SPAN_CORRECTION(sc), .DATA_OUT(dout),
		.DATA_READY(rdy), .CAL_BUSY(), .CAL_DONE(done), .SHORT_INPUTS(), .REF_TO_INPUT(),
		.TEMP_SENSE_SEL(tsel));
	// 40 MHz clock
	always #12.5 clk = ~clk;
	task automatic chk(logic [23:0] got, logic [23:0] want);
		checked++;
		if (got !== want) begin
			errors++;
			$display("[FAIL] %0t got %h want %h", $time, got, want);
		end
	endtask : chk
	// Bounded wait on ready (c=0) or calibration done (c=1)
	task automatic await(logic c, int lim);
		int n;
		n = 0;
		do begin
			@(posedge clk);
			#1;
			n++;
		end while ((c ? done : rdy) !== 1'b1 && n < lim);
		chk(c ? done : rdy, 1'b1);
	endtask : await
	// Reference result: offset, span, amplifier, unipolar fold, saturation
	function automatic logic [15:0] expo(logic [23:0] raw, logic u, logic [1:0] g);
		longint d;
		d = (longint'($signed(raw)) - longint'($signed(zexp))) * longint'(sexp);
		d = (d >>> 23) <<< g;
		d = u ? (d < 0 ? 0 : d * 2) : d;
		d = d >>> 7;
		return u ? (d > 65535 ? 16'hffff : d[15:0])
			: d > 32767 ? 16'h7fff : d < -32768 ? 16'h8000 : d[15:0];
	endfunction : expo
	task automatic conv(logic [23:0] raw, logic u, logic [1:0] g);
		@(posedge clk);
		go <= 1'b1;
		val <= raw;
		uni <= u;
		gain <= g;
		@(posedge clk);
		go <= 1'b0;
		await(1'b0, 8);
		chk(dout, expo(raw, u, g));
	endtask : conv
	task automatic wr(logic [23:0] z, logic [23:0] s);
		@(posedge clk);
		zwr <= 1'b1;
		swr <= 1'b1;
		zwd <= z;
		swd <= s;
		@(posedge clk);
		zwr <= 1'b0;
		swr <= 1'b0;
		#1;
		zexp = z;
		sexp = s;
		chk(zc, z);
		chk(sc, s);
	endtask : wr
	// Calibration; the stand-in supplies the raw level the kind needs
	task automatic cal(logic [1:0] k, logic [23:0] raw);
		longint d;
		@(posedge clk);
		cst <= 1'b1;
		kind <= k;
		@(posedge clk);
		cst <= 1'b0;
		go <= 1'b1;
		val <= raw;
		@(posedge clk);
		go <= 1'b0;
		await(1'b1, 60);
		d = longint'($signed(raw)) - longint'($signed(zexp));
		zexp = k[0] ? zexp : raw;
		sexp = !k[0] ? sexp : d <= 64'sd2097152 ? 24'hffffff : 24'((64'sd1 <<< 45) / d);
		chk(zc, zexp);
		chk(sc, sexp);
	endtask : cal
	task automatic results();
		if (errors == 0 && checked > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : results
	// Main sequence
	initial begin
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		#1;
		chk(zc, 24'h000000);
		chk(sc, 24'h800000);
		foreach (raws[i])
			for (int g = 0; g < 4; g++)
				for (int u = 0; u < 2; u++)
					conv(raws[i], u[0], g[1:0]);
		held = dout;
		wr(24'h001000, 24'h600000);
		@(posedge clk);
		uni <= ~uni;
		gain <= 2'h2;
		repeat (3) @(posedge clk);
		#1;
		chk(dout, held);
		conv(24'h300000, 1'b0, 2'h1);
		@(posedge clk);
		psel <= 4'h7;
		@(posedge clk);
		psel <= 4'h1;
		#1;
		chk(tsel, 1'b1);
		@(posedge clk);
		#1;
		chk(tsel, 1'b0);
		// Offset calibrated before gain for each kind; the system gain runs twice
		foreach (ckind[i]) begin
			cal(ckind[i], craw[i]);
			conv(24'h280000, 1'b1, 2'h1);
		end
		results();
	end
	// Watchdog, well past the expected run
	initial begin
		#50us;
		errors++;
		results();
	end
endmodule : tb_top
`default_nettype wire
